// ### design/nvm_cell_array.sv
// nonvolatile cell array with registered read data
`timescale 1ns/100ps
module nvm_cell_array import nvm_ctl_pkg::*; (
    // clock
    input wire logic CLK,
    // access port
    input mem_req_t req,
    output logic [7:0] rdata
);
    // cells keep their content over reset, so no reset here
    logic [7:0] cells [NVM_DEPTH];

    always_ff @(posedge CLK) begin
        if (req.we) begin
            // programming can only pull ones down to zero
            cells[req.addr] <= req.and_mode ?
                (cells[req.addr] & req.wdata) : req.wdata;
        end
        rdata <= cells[req.addr];
    end
endmodule : nvm_cell_array

// ### design/nvm_program_ctl.sv
// program/erase controller for the nvm array and setup register
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module nvm_program_ctl import nvm_ctl_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // register port
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // pins
    input wire logic SPECIAL_MODE,
    input wire logic SECURE,
    // array control
    output logic PROGRAM_VOLTAGE,
    output logic OTP_PROGRAM_MODE,
    output logic PUMP_CLOCK_SELECT,
    output logic SINGLE_CHIP_ONLY
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic mode_meta;
        logic mode_sync;
        logic sec_meta;
        logic sec_sync;
        logic [7:0] ctrl;
        logic pump_sel;
        logic armed;
        logic [9:0] cap_idx;
        logic [7:0] cap_data;
        op_t op;
        logic multi;
        logic and_mode;
        logic [7:0] op_data;
        logic [9:0] cnt;
        logic [9:0] last;
        logic rd_mem;
        logic [7:0] rd_data;
    } ctl_state_t;

    ctl_state_t q, d;
    mem_req_t mem;
    logic [7:0] mem_rdata;
    logic [7:0] w;
    logic [4:0] guard_bits;
    logic protect;
    logic guard_wr;
    logic volt_ok;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    nvm_cell_array u_cells (
        .CLK(CLK),
        .req(mem),
        .rdata(mem_rdata)
    );

    assign guard_wr = WR && ADDR == GUARD_ADDR;

    write_guard u_guard (
        .CLK(CLK),
        .RESET(RESET),
        .special(q.mode_sync),
        .wr_en(guard_wr),
        .wdata(WDATA[4:0]),
        .chk_idx(q.cnt),
        .guard_bits(guard_bits),
        .protect(protect)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        w = q.ctrl;
        volt_ok = 1'b0;
        d.mode_meta = SPECIAL_MODE;
        d.mode_sync = q.mode_meta;
        d.sec_meta = SECURE;
        d.sec_sync = q.sec_meta;
        d.rd_mem = 1'b0;
        d.rd_data = 8'h00;
        mem.we = 1'b0;
        mem.and_mode = q.and_mode;
        mem.addr = nvm_index(ADDR);
        mem.wdata = q.op_data;

        // reads: answer stands for the next cycle only
        if (RD) begin
            if (ADDR == CTRL_ADDR) begin
                d.rd_data = q.ctrl;
            end else if (ADDR == GUARD_ADDR) begin
                d.rd_data = {3'h0, guard_bits};
            end else if (ADDR == PUMP_ADDR) begin
                d.rd_data = {1'b0, q.pump_sel, 6'h00};
            end else if (is_nvm(ADDR)) begin
                // latched array hides its cells
                if (q.ctrl[B_LAT]) d.rd_data = ERASED;
                else d.rd_mem = 1'b1;
            end
        end

        if (WR && ADDR == PUMP_ADDR) begin
            d.pump_sel = WDATA[PUMP_SEL_BIT];
        end

        // control register write with its sequencing interlocks
        if (WR && ADDR == CTRL_ADDR) begin
            w = WDATA;
            if (w[B_OTP] && w[B_LAT]) begin
                w[B_OTP] = 1'b0;
                w[B_LAT] = 1'b0;
            end
            if (w[B_PGM] && !q.ctrl[B_LAT] && !q.ctrl[B_OTP]) begin
                w[B_OTP] = 1'b0;
                w[B_LAT] = 1'b0;
            end
            volt_ok = (w[B_LAT] && q.ctrl[B_LAT] && q.armed)
                || (w[B_OTP] && q.ctrl[B_OTP]);
            if (!volt_ok) w[B_PGM] = 1'b0;
            d.ctrl = w;
            if (!w[B_LAT]) d.armed = 1'b0;
        end

        // capture of address and data; frozen once voltage is on
        if (WR && is_nvm(ADDR) && q.ctrl[B_LAT] && !q.ctrl[B_PGM]) begin
            d.armed = 1'b1;
            d.cap_idx = nvm_index(ADDR);
            d.cap_data = WDATA;
        end

        unique case (q.op)
            OP_IDLE: begin
                // only the voltage turning on starts an operation
                if (d.ctrl[B_PGM] && !q.ctrl[B_PGM] && d.ctrl[B_LAT]) begin
                    d.op = OP_SWEEP;
                    d.and_mode = !d.ctrl[B_ERASE];
                    d.op_data = d.ctrl[B_ERASE] ? ERASED : q.cap_data;
                    d.multi = 1'b0;
                    d.cnt = q.cap_idx;
                    d.last = q.cap_idx;
                    // program and byte erase touch one cell only
                    if (d.ctrl[B_ERASE] && !d.ctrl[B_BYTE]
                        && q.cap_idx != CONFIG_IDX) begin
                        d.multi = 1'b1;
                        if (d.ctrl[B_ROW]) begin
                            d.cnt = {q.cap_idx[9:4], 4'h0};
                            d.last = {q.cap_idx[9:4], 4'h0} | ROW_LAST;
                        end else begin
                            // bulk stops short of the setup register
                            d.cnt = 10'h000;
                            d.last = ARRAY_LAST;
                        end
                    end
                end
            end
            OP_SWEEP: begin
                if (!q.ctrl[B_PGM]) begin
                    // voltage removed early: the rest is left as is
                    d.op = OP_IDLE;
                end else begin
                    mem.addr = q.cnt;
                    mem.we = !protect;
                    if (q.cnt == q.last) d.op = OP_HOLD;
                    else d.cnt = q.cnt + 10'h001;
                end
            end
            OP_HOLD: begin
                // one operation per voltage pulse
                if (!q.ctrl[B_PGM]) d.op = OP_IDLE;
            end
            default: begin
                d.op = OP_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            q.mode_meta <= 1'b0;
            q.mode_sync <= 1'b0;
            q.sec_meta <= 1'b0;
            q.sec_sync <= 1'b0;
            q.ctrl <= CTRL_RESET;
            q.pump_sel <= 1'b0;
            q.armed <= 1'b0;
            q.cap_idx <= 10'h000;
            q.cap_data <= 8'h00;
            q.op <= OP_IDLE;
            q.multi <= 1'b0;
            q.and_mode <= 1'b0;
            q.op_data <= 8'h00;
            q.cnt <= 10'h000;
            q.last <= 10'h000;
            q.rd_mem <= 1'b0;
            q.rd_data <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign RDATA = q.rd_mem ? mem_rdata : q.rd_data;
    // the voltage gates the charge pump straight from the register
    assign PROGRAM_VOLTAGE = q.ctrl[B_PGM];
    assign OTP_PROGRAM_MODE = q.ctrl[B_OTP];
    assign PUMP_CLOCK_SELECT = q.pump_sel;
    // secured part keeps its internal buses off the pins
    assign SINGLE_CHIP_ONLY = q.sec_sync;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    a_latch_exclusive: assert property (
        !(q.ctrl[B_OTP] && q.ctrl[B_LAT]))
        else $error("both latch bits set");

    a_single_write: assert property (
        WR && ADDR == CTRL_ADDR && WDATA[B_LAT] && WDATA[B_PGM]
        && !q.ctrl[B_LAT] && !q.ctrl[B_OTP]
        |=> !q.ctrl[B_LAT] && !q.ctrl[B_PGM])
        else $error("latch and voltage set in one write");

    a_voltage_armed: assert property (
        $rose(q.ctrl[B_PGM]) && q.ctrl[B_LAT]
        |-> $past(q.armed) && $past(q.ctrl[B_LAT]))
        else $error("voltage on without captured write");

    a_read_hidden: assert property (
        RD && is_nvm(ADDR) && q.ctrl[B_LAT] |=> RDATA == ERASED)
        else $error("latched array was readable");

    a_write_latched: assert property (
        mem.we |-> q.ctrl[B_LAT] && q.ctrl[B_PGM] && q.op == OP_SWEEP)
        else $error("cell write outside a voltage pulse");

    a_capture_frozen: assert property (
        $past(q.ctrl[B_PGM]) |-> $stable(q.cap_idx) && $stable(q.cap_data))
        else $error("capture changed under voltage");

    a_erase_data: assert property (
        mem.we && !mem.and_mode |-> mem.wdata == ERASED)
        else $error("erase wrote other than ones");

    a_bulk_spares: assert property (
        mem.we && q.multi |-> mem.addr != CONFIG_IDX)
        else $error("multi-byte erase hit setup register");

    a_guard_kept: assert property (
        mem.we |-> !block_locked(guard_bits, mem.addr))
        else $error("guarded cell was written");

    a_single_cell: assert property (
        q.op == OP_SWEEP && !q.multi && q.ctrl[B_PGM]
        |=> q.op == OP_HOLD)
        else $error("single cell op ran more than one cycle");

    a_row_span: assert property (
        q.op == OP_IDLE && d.op == OP_SWEEP && d.multi && d.ctrl[B_ROW]
        |=> q.last - q.cnt == ROW_LAST && q.cnt[3:0] == 4'h0)
        else $error("row erase span not sixteen bytes");

    a_program_mode: assert property (
        q.op == OP_IDLE && d.op == OP_SWEEP && !d.ctrl[B_ERASE]
        |=> !q.multi && q.and_mode && q.op_data == q.cap_data)
        else $error("program not a single masked write");

    a_voltage_latched: assert property (
        q.ctrl[B_PGM] |-> q.ctrl[B_LAT] || q.ctrl[B_OTP])
        else $error("voltage on without a latch bit");

    a_sweep_abort: assert property (
        q.op != OP_IDLE && !q.ctrl[B_PGM] |=> q.op == OP_IDLE)
        else $error("operation kept running without voltage");

    a_hold_once: assert property (
        q.op == OP_HOLD && q.ctrl[B_PGM] |=> q.op == OP_HOLD)
        else $error("second operation in one voltage pulse");

    a_bulk_span: assert property (
        q.op == OP_IDLE && d.op == OP_SWEEP && d.multi && !d.ctrl[B_ROW]
        |=> q.cnt == 10'h000 && q.last == ARRAY_LAST)
        else $error("bulk erase span not the whole array");

    a_byte_single: assert property (
        q.op == OP_IDLE && d.op == OP_SWEEP && d.ctrl[B_BYTE]
        |=> !q.multi && q.cnt == q.last)
        else $error("byte erase touched more than one cell");

    a_erase_ones: assert property (
        q.op == OP_IDLE && d.op == OP_SWEEP && d.ctrl[B_ERASE]
        |=> !q.and_mode && q.op_data == ERASED)
        else $error("erase did not select all-ones data");

    a_sweep_walk: assert property (
        q.op == OP_SWEEP && q.ctrl[B_PGM] && q.cnt != q.last
        |=> q.op == OP_SWEEP && q.cnt == $past(q.cnt) + 10'h001)
        else $error("sweep skipped or repeated a cell");

    a_read_control: assert property (
        RD && ADDR == CTRL_ADDR |=> RDATA == $past(q.ctrl))
        else $error("control register read back wrong");

    a_guard_read: assert property (
        RD && ADDR == GUARD_ADDR |=> RDATA == {3'h0, $past(guard_bits)})
        else $error("guard register read back wrong");

    a_capture_latched: assert property (
        $changed(q.cap_idx) || $changed(q.cap_data)
        |-> $past(WR) && $past(q.ctrl[B_LAT]) && !$past(q.ctrl[B_PGM]))
        else $error("capture without latch bit");

    a_unmapped_zero: assert property (
        RD && !is_nvm(ADDR) && ADDR != CTRL_ADDR && ADDR != GUARD_ADDR
        && ADDR != PUMP_ADDR |=> RDATA == 8'h00)
        else $error("unmapped read not zero");

    c_program: cover property (
        q.op == OP_SWEEP && q.and_mode && mem.we);
    c_row_erase: cover property (
        q.op == OP_SWEEP && q.multi && q.ctrl[B_ROW] && mem.we);
    c_bulk_erase: cover property (
        q.op == OP_SWEEP && q.multi && q.cnt == ARRAY_LAST);
    c_setup_erase: cover property (
        mem.we && mem.addr == CONFIG_IDX && !mem.and_mode);
    c_byte_erase: cover property (
        q.op == OP_SWEEP && !q.multi && !q.and_mode && mem.we);

endmodule : nvm_program_ctl

// ### design/write_guard.sv
// block write guard register with its after-reset clear window
`timescale 1ns/100ps
module write_guard import nvm_ctl_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // control
    input wire logic special,
    input wire logic wr_en,
    input wire logic [4:0] wdata,
    input wire logic [9:0] chk_idx,
    // status
    output logic [4:0] guard_bits,
    output logic protect
);
    typedef struct packed {
        logic [4:0] bits;
        logic [6:0] win;
    } guard_state_t;

    guard_state_t q, d;

    always_comb begin
        d = q;
        if (q.win < GUARD_WINDOW) d.win = q.win + 7'h01;
        if (wr_en) begin
            // normal modes may only clear inside the window; setting always works
            if (special || q.win < GUARD_WINDOW) d.bits = wdata;
            else d.bits = q.bits | wdata;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            q.bits <= GUARD_RESET;
            q.win <= 7'h00;
        end else begin
            q <= d;
        end
    end

    assign guard_bits = q.bits;
    assign protect = block_locked(q.bits, chk_idx);
endmodule : write_guard

// ### pkg/nvm_ctl_pkg.sv
// constants, types and decode helpers for the nvm program/erase controller
// Notes on behaviour
// - erase with byte clear: row bit picks row/bulk, except the setup register erases alone
// - byte bit set erases one byte only
// - erase bit picks erase over program
// - latch set: capture writes, block reads
// - voltage bit switches programming voltage
// - otp latch and nvm latch never both
// - otp latch selects otp programming path
// - program ignores row and byte bits
// - bulk erase leaves setup register alone
// - setup register uses array byte sequences
// - setup register changeable when its guard clear
// - security forces single chip operation
// - latch and voltage in one write: neither
// - voltage only after latch, capture, latch+volt; otp voltage needs only the otp latch set first
// - guarded blocks are never changed
// - erased reads one, program only clears bits
package nvm_ctl_pkg;

    // ----------------------------------------------------------------
    // register map and array geometry
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_ADDR = 16'h103b;
    localparam logic [15:0] GUARD_ADDR = 16'h1035;
    localparam logic [15:0] PUMP_ADDR = 16'h1039;
    localparam logic [15:0] CONFIG_ADDR = 16'h103f;
    localparam logic [15:0] ARRAY_BASE = 16'hb600;
    localparam logic [15:0] ARRAY_END = 16'hb7ff;
    localparam logic [9:0] ARRAY_LAST = 10'h1ff;
    localparam logic [9:0] CONFIG_IDX = 10'h200;
    localparam logic [9:0] ROW_LAST = 10'h00f;
    localparam int NVM_DEPTH = 1024;
    localparam logic [9:0] BLK1_START = 10'h020;
    localparam logic [9:0] BLK2_START = 10'h060;
    localparam logic [9:0] BLK3_START = 10'h0e0;

    // ----------------------------------------------------------------
    // control register fields and reset values
    // ----------------------------------------------------------------
    localparam int B_ODD = 7;
    localparam int B_EVEN = 6;
    localparam int B_OTP = 5;
    localparam int B_BYTE = 4;
    localparam int B_ROW = 3;
    localparam int B_ERASE = 2;
    localparam int B_LAT = 1;
    localparam int B_PGM = 0;
    localparam int PUMP_SEL_BIT = 6;
    localparam int GUARD_CFG_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] GUARD_RESET = 5'h1f;
    localparam logic [6:0] GUARD_WINDOW = 7'h40;
    localparam logic [7:0] ERASED = 8'hff;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_SWEEP = 2'b01,
        OP_HOLD = 2'b10
    } op_t;

    typedef struct packed {
        logic we;
        logic and_mode;
        logic [9:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_nvm(input logic [15:0] a);
        return (a >= ARRAY_BASE && a <= ARRAY_END) || a == CONFIG_ADDR;
    endfunction : is_nvm

    function automatic logic [9:0] nvm_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - ARRAY_BASE;
        return (a == CONFIG_ADDR) ? CONFIG_IDX : off[9:0];
    endfunction : nvm_index

    function automatic logic block_locked(input logic [4:0] g,
                                          input logic [9:0] idx);
        if (idx == CONFIG_IDX) return g[GUARD_CFG_BIT];
        if (idx < BLK1_START) return g[0];
        if (idx < BLK2_START) return g[1];
        if (idx < BLK3_START) return g[2];
        return g[3];
    endfunction : block_locked

endpackage : nvm_ctl_pkg

// ### tb/eeprom_program_erase_control_test.sv
// self-checking bench for the nvm program/erase controller
`timescale 1ns/100ps
module eeprom_program_erase_control_test import nvm_ctl_pkg::*; ();

    // ------------------------------------------------------------
    // signals and design instance
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic reset;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic special;
    logic secure;
    logic pgm_v;
    logic otp_mode;
    logic pump_sel;
    logic single_chip;
    int fail_count = 0;
    int comparisons = 0;

    nvm_program_ctl dut (
        .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SPECIAL_MODE(special),
        .SECURE(secure), .PROGRAM_VOLTAGE(pgm_v),
        .OTP_PROGRAM_MODE(otp_mode), .PUMP_CLOCK_SELECT(pump_sel),
        .SINGLE_CHIP_ONLY(single_chip)
    );

    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // each access starts one edge later so a strobe is never driven
    // twice in one time step
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask : rd_chk

    // full latch, capture, voltage, off sequence; 600 cycles covers
    // the 512-cell bulk sweep with margin
    task automatic op(input logic [7:0] ctl, input logic [15:0] a,
                      input logic [7:0] d);
        wr_reg(CTRL_ADDR, ctl & 8'hfe);
        wr_reg(a, d);
        wr_reg(CTRL_ADDR, ctl);
        @(negedge clk);
        check({7'h00, pgm_v}, 8'h01);
        repeat (600) @(posedge clk);
        wr_reg(CTRL_ADDR, 8'h00);
        @(negedge clk);
        check({7'h00, pgm_v}, 8'h00);
    endtask : op

    task automatic print_verdict;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // watchdog: the sequence needs about 1 ms
    // ------------------------------------------------------------
    initial begin
        #5000000;
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        addr = 16'h0000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        special = 1'b0;
        secure = 1'b0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // guard must be cleared inside the 64-cycle window
        rd_chk(CTRL_ADDR, CTRL_RESET);
        rd_chk(GUARD_ADDR, {3'b000, GUARD_RESET});
        wr_reg(GUARD_ADDR, 8'h00);
        rd_chk(GUARD_ADDR, 8'h00);
        rd_chk(16'h1000, 8'h00);
        // setup register: byte erase then program
        op(8'h17, CONFIG_ADDR, 8'h00);
        rd_chk(CONFIG_ADDR, ERASED);
        op(8'h03, CONFIG_ADDR, 8'h5a);
        rd_chk(CONFIG_ADDR, 8'h5a);
        // setup change ends with a reset; the cells keep their value
        @(posedge clk);
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd_chk(CTRL_ADDR, CTRL_RESET);
        rd_chk(GUARD_ADDR, {3'b000, GUARD_RESET});
        rd_chk(CONFIG_ADDR, 8'h5a);
        wr_reg(GUARD_ADDR, 8'h00);
        // bulk erase spares the setup register
        op(8'h07, ARRAY_BASE + 16'h0123, 8'h00);
        for (int i = 0; i < 512; i += 73) begin
            rd_chk(ARRAY_BASE + 16'(i), ERASED);
        end
        rd_chk(ARRAY_END, ERASED);
        rd_chk(CONFIG_ADDR, 8'h5a);
        // programming only clears bits
        op(8'h03, 16'hb610, 8'ha5);
        rd_chk(16'hb610, 8'ha5);
        op(8'h03, 16'hb610, 8'h0f);
        rd_chk(16'hb610, 8'h05);
        wr_reg(CTRL_ADDR, 8'h02);
        rd_chk(16'hb610, ERASED);
        wr_reg(CTRL_ADDR, 8'h00);
        rd_chk(16'hb610, 8'h05);
        // row and byte bits mean nothing without the erase bit
        op(8'h1b, 16'hb620, 8'h3c);
        rd_chk(16'hb620, 8'h3c);
        rd_chk(16'hb621, ERASED);
        // row erase stays inside its 16-byte row
        op(8'h03, 16'hb630, 8'h00);
        op(8'h03, 16'hb63f, 8'h00);
        op(8'h03, 16'hb640, 8'h00);
        op(8'h03, 16'hb641, 8'h00);
        op(8'h0f, 16'hb635, 8'h00);
        rd_chk(16'hb630, ERASED);
        rd_chk(16'hb63f, ERASED);
        rd_chk(16'hb640, 8'h00);
        // byte bit overrides the row bit
        op(8'h1f, 16'hb640, 8'h00);
        rd_chk(16'hb640, ERASED);
        rd_chk(16'hb641, 8'h00);
        // voltage enable sequencing
        wr_reg(CTRL_ADDR, 8'h03);
        rd_chk(CTRL_ADDR, 8'h00);
        wr_reg(CTRL_ADDR, 8'h02);
        wr_reg(CTRL_ADDR, 8'h03);
        rd_chk(CTRL_ADDR, 8'h02);
        wr_reg(CTRL_ADDR, 8'h22);
        rd_chk(CTRL_ADDR, 8'h00);
        wr_reg(CTRL_ADDR, 8'h20);
        @(negedge clk);
        check({7'h00, otp_mode}, 8'h01);
        wr_reg(CTRL_ADDR, 8'h21);
        @(negedge clk);
        check({7'h00, pgm_v}, 8'h01);
        wr_reg(CTRL_ADDR, 8'h00);
        @(negedge clk);
        check({7'h00, otp_mode}, 8'h00);
        // capture is frozen while the voltage is on
        wr_reg(CTRL_ADDR, 8'h02);
        wr_reg(16'hb650, 8'hf0);
        wr_reg(CTRL_ADDR, 8'h03);
        wr_reg(16'hb651, 8'h00);
        wr_reg(16'hb650, 8'h00);
        repeat (20) @(posedge clk);
        wr_reg(CTRL_ADDR, 8'h00);
        rd_chk(16'hb650, 8'hf0);
        rd_chk(16'hb651, ERASED);
        // after the window, guard bits can only be set
        wr_reg(GUARD_ADDR, 8'h01);
        wr_reg(GUARD_ADDR, 8'h00);
        rd_chk(GUARD_ADDR, 8'h01);
        op(8'h03, ARRAY_BASE, 8'h00);
        rd_chk(ARRAY_BASE, ERASED);
        // pump clock select
        wr_reg(PUMP_ADDR, 8'hff);
        rd_chk(PUMP_ADDR, 8'h40);
        check({7'h00, pump_sel}, 8'h01);
        // security and special mode pins pass two sync flops
        @(posedge clk);
        secure <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({7'h00, single_chip}, 8'h01);
        @(posedge clk);
        special <= 1'b1;
        repeat (4) @(posedge clk);
        wr_reg(GUARD_ADDR, 8'h00);
        rd_chk(GUARD_ADDR, 8'h00);
        print_verdict();
    end

endmodule : eeprom_program_erase_control_test
